/* File: gcp_pkg.sv */
// constants, field layout and state encoding of the gauge command port
package gcp_pkg;
  // seven-bit slave address 1010101, so 0xaa writes and 0xab reads
  localparam logic [6:0] SLAVE_ADDR = 7'h55;
  localparam logic [7:0] TOP_CMD = 8'h6b;
  localparam logic [7:0] APP_STATUS_LOC = 8'h6a;
  localparam int CMD_LOCS = 108;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BEYOND_TOP_BYTE = 8'hff;
  localparam logic [107:0] RO_MASK_DEFAULT = 108'h1 << 106;
  // time base
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TIMEOUT_UNIT_MS = 500;
  localparam int unsigned FLASH_STRETCH_MS = 80;
  localparam int unsigned OCV_STRETCH_MS = 270;
  localparam int unsigned TIMEOUT_UNIT_CYCLES = CLK_HZ / 1000 * TIMEOUT_UNIT_MS;
  localparam int unsigned FLASH_STRETCH_CYCLES = CLK_HZ / 1000 * FLASH_STRETCH_MS;
  localparam int unsigned OCV_STRETCH_CYCLES = CLK_HZ / 1000 * OCV_STRETCH_MS;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD = 3'b010,
    ST_WDATA = 3'b011,
    ST_ACK = 3'b100,
    ST_RDATA = 3'b101,
    ST_MACK = 3'b110
  } gcp_state_t;
endpackage

/* File: gcp_bus_watch.sv */
// low-bus watchdog: half-second tick divider, timeout pulse and stuck level
`timescale 1ns/1ns
`default_nettype none
module gcp_bus_watch
  import gcp_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = TIMEOUT_UNIT_CYCLES
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [7:0] timeout_count_in,
  output logic timeout_out,
  output logic stuck_out
);
  logic [31:0] div_reg;
  logic [7:0] units_reg;
  logic fired_reg;
  logic fired_d_reg;
  logic timeout_reg;
  logic stuck_reg;

  // any line low counts; a high bus restarts the whole watch
  wire bus_low = ~scl_in | ~sda_in;
  wire unit_tick = bus_low & (div_reg == UNIT_CYCLES - 1);
  wire fire = bus_low & ~fired_reg & (timeout_count_in != 8'h00) & (units_reg == timeout_count_in);

  // a zero count disables the watch, so a slow master is never cut off
  always_ff @(posedge mclk_in) begin
    if (reset_in || !bus_low) begin
      div_reg <= 32'h0;
      units_reg <= 8'h00;
      fired_reg <= 1'b0;
      fired_d_reg <= 1'b0;
      timeout_reg <= 1'b0;
      stuck_reg <= 1'b0;
    end else begin
      div_reg <= unit_tick ? 32'h0 : div_reg + 32'h1;
      units_reg <= (unit_tick && units_reg != 8'hff) ? units_reg + 8'h01 : units_reg;
      fired_reg <= fired_reg | fire;
      fired_d_reg <= fired_reg;
      timeout_reg <= fire;
      stuck_reg <= stuck_reg | fired_d_reg;
    end
  end

  assign timeout_out = timeout_reg;
  assign stuck_out = stuck_reg;

  // stuck only reported while a line is really still low
  AST_STUCK_LOW: assert property (@(posedge mclk_in) disable iff (reset_in) stuck_out |-> $past(bus_low))
    else $error("stuck level without a low bus");
endmodule
`default_nettype wire

/* File: gcp_command_port.sv */
// two-wire slave command port of the fuel gauge with pointer, timeout and stretch
// Function
// - answer only to seven-bit address 1010101
// - serve single, incremental, quick reads and writes
// - quick read returns byte at pointer
// - pointer advances on every acknowledged data byte
// - successive written bytes fill consecutive locations
// - write to read-only location gets NACK
// - command byte above 0x6b gets NACK
// - release both lines after timeout count halves
// - still low after timeout: engine sleeps
// - stretch clock up to 80ms during flash
// - stretch clock up to 270ms after OCV
// - last profile status readable at 0x6a
// - status bit0 names last profile, default 0
// - set OCV done flag when measurement ends
// - flag reports whether OCV reading is valid
// - set init done flag after impedance compare
// - wake from hibernate only on own address
`timescale 1ns/1ns
`default_nettype none
module gcp_command_port
  import gcp_pkg::*;
#(
  parameter int unsigned TIMEOUT_UNIT_CYCLES_P = TIMEOUT_UNIT_CYCLES,
  parameter int unsigned FLASH_STRETCH_CYCLES_P = FLASH_STRETCH_CYCLES,
  parameter int unsigned OCV_STRETCH_CYCLES_P = OCV_STRETCH_CYCLES,
  parameter logic [CMD_LOCS-1:0] RO_MASK = RO_MASK_DEFAULT
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [7:0] bus_timeout_count_in,
  input wire logic stretch_req_in,
  input wire logic stretch_ocv_in,
  input wire logic hibernate_in,
  output logic wake_out,
  output logic sleep_out,
  input wire logic core_wr_in,
  input wire logic [7:0] core_addr_in,
  input wire logic [7:0] core_data_in,
  output logic wr_strobe_out,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  input wire logic last_used_profile_bit_in,
  input wire logic ocv_start_in,
  input wire logic ocv_meas_done_in,
  input wire logic ocv_load_high_in,
  input wire logic init_cmp_done_in,
  output logic ocv_done_flag_out,
  output logic ocv_invalid_flag_out,
  output logic init_done_flag_out
);
  gcp_state_t state_reg, state_next;
  gcp_state_t ack_to_reg, ack_to_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic [3:0] cnt_reg, cnt_next;
  logic mack_reg, mack_next;
  logic wake_reg, wake_next;
  logic host_wr;
  logic scl_q_reg, sda_q_reg;
  logic hold_reg, hold_next;
  logic [31:0] stretch_cnt_reg, stretch_cnt_next;
  logic profile_reg;
  logic ocv_done_reg, ocv_done_next;
  logic ocv_invalid_reg, ocv_invalid_next;
  logic init_done_reg, init_done_next;
  logic wr_strobe_reg;
  logic [7:0] wr_addr_reg, wr_data_reg;
  logic [7:0] mem [0:CMD_LOCS-1];
  logic timeout_pulse;
  logic bus_stuck;

  // location lies at or below the top and is not marked read-only
  function automatic logic is_writable(input logic [7:0] loc);
    is_writable = (loc <= TOP_CMD) && !RO_MASK[loc[6:0]];
  endfunction

  // bus conditions from the previous sample of both lines
  wire start_det = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
  wire stop_det = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
  wire scl_rise = scl_in & ~scl_q_reg;
  wire scl_fall = ~scl_in & scl_q_reg;
  wire byte_fall = scl_fall & (cnt_reg == BYTE_BITS);
  wire addr_match = shift_reg[7:1] == SLAVE_ADDR;
  wire read_req = shift_reg[0];
  wire cmd_bad = shift_reg > TOP_CMD;
  wire wr_ok = is_writable(ptr_reg);
  wire receiving = (state_reg == ST_ADDR) | (state_reg == ST_CMD) | (state_reg == ST_WDATA);
  wire [31:0] stretch_cap = stretch_ocv_in ? OCV_STRETCH_CYCLES_P : FLASH_STRETCH_CYCLES_P;

  // read data source: status byte, command memory or idle ones above the top
  wire [7:0] rd_data = (ptr_reg == APP_STATUS_LOC) ? {7'h00, profile_reg} :
                       (ptr_reg <= TOP_CMD) ? mem[ptr_reg[6:0]] : BEYOND_TOP_BYTE;

  gcp_bus_watch #(
    .UNIT_CYCLES(TIMEOUT_UNIT_CYCLES_P)
  ) u_watch (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .timeout_count_in(bus_timeout_count_in),
    .timeout_out(timeout_pulse),
    .stuck_out(bus_stuck)
  );

  // byte engine; start, stop and timeout override the next state, start also clears the bit count
  always_comb begin
    state_next = state_reg;
    ack_to_next = ack_to_reg;
    ptr_next = ptr_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    cnt_next = cnt_reg;
    mack_next = mack_reg;
    wake_next = 1'b0;
    host_wr = 1'b0;
    if (scl_rise && receiving && cnt_reg < BYTE_BITS) begin
      shift_next = {shift_reg[6:0], sda_in};
      cnt_next = cnt_reg + 4'h1;
    end
    if (scl_rise && state_reg == ST_RDATA && cnt_reg < BYTE_BITS) begin
      cnt_next = cnt_reg + 4'h1;
    end
    case (state_reg)
      ST_ADDR: begin
        if (byte_fall) begin
          if (addr_match) begin
            wake_next = hibernate_in;
            ack_to_next = read_req ? ST_RDATA : ST_CMD;
            tx_next = rd_data;
            state_next = ST_ACK;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_CMD: begin
        if (byte_fall) begin
          if (cmd_bad) begin
            state_next = ST_IDLE;
          end else begin
            ptr_next = shift_reg;
            ack_to_next = ST_WDATA;
            state_next = ST_ACK;
          end
        end
      end
      ST_WDATA: begin
        if (byte_fall) begin
          if (wr_ok) begin
            host_wr = 1'b1;
            ptr_next = ptr_reg + 8'h01;
            ack_to_next = ST_WDATA;
            state_next = ST_ACK;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          state_next = ack_to_reg;
          cnt_next = 4'h0;
        end
      end
      ST_RDATA: begin
        if (scl_fall) begin
          if (cnt_reg == BYTE_BITS) begin
            state_next = ST_MACK;
            mack_next = 1'b0;
          end else begin
            tx_next = {tx_reg[6:0], 1'b1};
          end
        end
      end
      ST_MACK: begin
        if (scl_rise) begin
          mack_next = ~sda_in;
          if (!sda_in) begin
            ptr_next = ptr_reg + 8'h01;
          end
        end
        if (scl_fall) begin
          if (mack_reg) begin
            tx_next = rd_data;
            cnt_next = 4'h0;
            state_next = ST_RDATA;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = state_reg;
      end
    endcase
    if (start_det) begin
      state_next = ST_ADDR;
      cnt_next = 4'h0;
    end else if (stop_det || timeout_pulse) begin
      state_next = ST_IDLE;
    end
  end

  // clock stretch is taken at the end of an ack and capped in cycles
  assign hold_next = timeout_pulse ? 1'b0 :
                     (state_reg == ST_ACK && scl_fall && stretch_req_in) ? 1'b1 :
                     hold_reg & stretch_req_in & (stretch_cnt_reg + 32'h1 < stretch_cap);
  assign stretch_cnt_next = hold_reg ? stretch_cnt_reg + 32'h1 : 32'h0;

  // measurement flags: a new completion wins over the clear from a new start
  assign ocv_done_next = ocv_meas_done_in | (ocv_done_reg & ~ocv_start_in);
  assign ocv_invalid_next = ocv_meas_done_in ? ocv_load_high_in : (ocv_invalid_reg & ~ocv_start_in);
  assign init_done_next = init_cmp_done_in | init_done_reg;

  // line state, engine state and pointer
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      state_reg <= ST_IDLE;
      ack_to_reg <= ST_IDLE;
      ptr_reg <= RESET_BYTE;
      shift_reg <= RESET_BYTE;
      tx_reg <= RESET_BYTE;
      cnt_reg <= 4'h0;
      mack_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      scl_q_reg <= scl_in;
      sda_q_reg <= sda_in;
      state_reg <= state_next;
      ack_to_reg <= ack_to_next;
      ptr_reg <= ptr_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      cnt_reg <= cnt_next;
      mack_reg <= mack_next;
      wake_reg <= wake_next;
    end
  end

  // stretch, flags and status byte source
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hold_reg <= 1'b0;
      stretch_cnt_reg <= 32'h0;
      profile_reg <= 1'b0;
      ocv_done_reg <= 1'b0;
      ocv_invalid_reg <= 1'b0;
      init_done_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      stretch_cnt_reg <= stretch_cnt_next;
      profile_reg <= last_used_profile_bit_in;
      ocv_done_reg <= ocv_done_next;
      ocv_invalid_reg <= ocv_invalid_next;
      init_done_reg <= init_done_next;
    end
  end

  // command memory; a host write beats a core write in the same cycle
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int i = 0; i < CMD_LOCS; i++) begin
        mem[i] <= RESET_BYTE;
      end
    end else if (host_wr) begin
      mem[ptr_reg[6:0]] <= shift_reg;
    end else if (core_wr_in && core_addr_in <= TOP_CMD) begin
      mem[core_addr_in[6:0]] <= core_data_in;
    end
  end

  // write notice to the gauge core, one pulse per byte stored by the host
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_strobe_reg <= 1'b0;
      wr_addr_reg <= RESET_BYTE;
      wr_data_reg <= RESET_BYTE;
    end else begin
      wr_strobe_reg <= host_wr;
      wr_addr_reg <= host_wr ? ptr_reg : wr_addr_reg;
      wr_data_reg <= host_wr ? shift_reg : wr_data_reg;
    end
  end

  // open drain: only low is ever driven, the pull-up makes the high
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe_out = (state_reg == ST_ACK) | ((state_reg == ST_RDATA) & ~tx_reg[7]);
  assign scl_oe_out = hold_reg;
  assign wake_out = wake_reg;
  assign sleep_out = bus_stuck;
  assign wr_strobe_out = wr_strobe_reg;
  assign wr_addr_out = wr_addr_reg;
  assign wr_data_out = wr_data_reg;
  assign ocv_done_flag_out = ocv_done_reg;
  assign ocv_invalid_flag_out = ocv_invalid_reg;
  assign init_done_flag_out = init_done_reg;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  // address acknowledge or silence, checked after the eighth bit
  AST_ADDR_ACK: assert property ((state_reg == ST_ADDR && byte_fall && addr_match && !start_det && !timeout_pulse)
    |=> sda_oe_out ##1 (sda_oe_out || state_reg != ST_ACK))
    else $error("own address not acknowledged");
  AST_ADDR_FOREIGN: assert property ((state_reg == ST_ADDR && byte_fall && !addr_match && !start_det)
    |=> state_reg == ST_IDLE && !sda_oe_out && !wake_out)
    else $error("foreign address taken");
  AST_QUICK_READ: assert property ((state_reg == ST_ADDR && byte_fall && addr_match && read_req && !start_det)
    |=> tx_reg == $past(rd_data))
    else $error("quick read not from pointer");
  AST_WRITE_INC: assert property ((state_reg == ST_WDATA && byte_fall && wr_ok && !start_det)
    |=> ptr_reg == $past(ptr_reg) + 8'h01 && wr_strobe_out ##1 !wr_strobe_out || start_det)
    else $error("write did not advance pointer");
  AST_MACK_INC: assert property ((state_reg == ST_MACK && scl_rise && !sda_in && !start_det)
    |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("master ack did not advance pointer");
  AST_RO_NACK: assert property ((state_reg == ST_WDATA && byte_fall && !wr_ok && !start_det)
    |=> !sda_oe_out && !wr_strobe_out && state_reg == ST_IDLE)
    else $error("read-only location acknowledged");
  AST_CMD_TOP: assert property ((state_reg == ST_CMD && byte_fall && cmd_bad && !start_det)
    |=> !sda_oe_out && state_reg == ST_IDLE)
    else $error("command above top acknowledged");
  AST_TIMEOUT_FREE: assert property (timeout_pulse |=> !scl_oe_out && !sda_oe_out)
    else $error("lines held after timeout");
  AST_STRETCH_CAP: assert property (hold_reg |-> stretch_cnt_reg < stretch_cap)
    else $error("stretch beyond its cap");
  AST_STRETCH_END: assert property ((hold_reg && !stretch_req_in) |=> !scl_oe_out)
    else $error("stretch kept after request ended");
  AST_STATUS_BYTE: assert property ((state_reg == ST_ADDR && byte_fall && addr_match && read_req && !start_det
    && ptr_reg == APP_STATUS_LOC) |=> tx_reg == {7'h00, $past(last_used_profile_bit_in, 2)})
    else $error("status byte wrong");
  AST_OCV_DONE: assert property (ocv_meas_done_in |=> ocv_done_flag_out && ocv_invalid_flag_out == $past(ocv_load_high_in))
    else $error("ocv flags not taken");
  AST_INIT_DONE: assert property (init_cmp_done_in |=> init_done_flag_out [*2])
    else $error("init flag not sticky");

  COV_WRITE: cover property (wr_strobe_out ##[1:400] wr_strobe_out);
  COV_READ_ACK: cover property (state_reg == ST_MACK && scl_rise && !sda_in);
  COV_STRETCH: cover property (hold_reg [*3]);
  COV_TIMEOUT: cover property (timeout_pulse);
endmodule
`default_nettype wire

/* File: gcp_host_model.sv */
// two-wire bus master model with open-drain line drivers
`timescale 1ns/1ns
`default_nettype none
module gcp_host_model #(
  parameter int PHASE = 5
) (
  input wire logic mclk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_low_out,
  output logic sda_low_out,
  output logic hang_out
);
  // released lines float high through the pull-ups
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
    hang_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  // raise the clock and wait out any stretching, bounded
  task automatic scl_up();
    int w;
    scl_low_out = 1'b0;
    w = 0;
    tick(1);
    while (scl_in !== 1'b1 && w < 2000) begin
      tick(1);
      w++;
    end
    if (w >= 2000) hang_out = 1'b1;
    tick(PHASE);
  endtask
  // one bit: data changes only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    sda_low_out = ~b;
    tick(PHASE);
    scl_up();
    r = sda_in;
    scl_low_out = 1'b1;
    tick(1);
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    tick(PHASE);
    scl_up();
    sda_low_out = 1'b1;
    tick(PHASE);
    scl_low_out = 1'b1;
    tick(1);
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    tick(PHASE);
    scl_up();
    sda_low_out = 1'b0;
    tick(PHASE);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~mack, r);
  endtask
  // holding data low with the clock high looks like a stuck bus
  task automatic hold(input logic on);
    sda_low_out = on;
    tick(PHASE);
  endtask
endmodule
`default_nettype wire

/* File: gauge_i2c_command_port_bench.sv */
// self-checking bench for the gauge command port
`timescale 1ns/1ns
`default_nettype none
module gauge_i2c_command_port_bench;
  import gcp_pkg::*;
  localparam int UNIT = 50;
  localparam int FCAP = 20;
  localparam int OCAP = 40;
  localparam int HOST_WAIT = 10;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic str_req = 1'b0;
  logic str_ocv = 1'b0;
  logic hib = 1'b0;
  logic core_wr = 1'b0;
  logic lu_bit = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [7:0] tmo = 8'h00;
  logic [7:0] core_addr = 8'h00;
  logic [7:0] core_data = 8'h00;
  logic scl_w, sda_w, h_scl, h_sda, hang, scl_oe, sda_oe, wake, sleep, stb;
  logic ocv_done, ocv_inv, init_done;
  logic [7:0] wr_addr, wr_data;
  int fail_count = 0;
  int n_checks = 0;
  int wakes = 0;
  int strobes = 0;
  int run = 0;
  int max_run = 0;
  // wire-and of both parties with pull-ups
  assign scl_w = ~(h_scl | scl_oe);
  assign sda_w = ~(h_sda | sda_oe);
  initial begin
    forever #10 mclk_in = ~mclk_in;
  end
  gcp_command_port #(.TIMEOUT_UNIT_CYCLES_P(UNIT), .FLASH_STRETCH_CYCLES_P(FCAP),
    .OCV_STRETCH_CYCLES_P(OCAP)) u_dut (.mclk_in(mclk_in), .reset_in(reset_in), .scl_in(scl_w),
    .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe),
    .bus_timeout_count_in(tmo), .stretch_req_in(str_req), .stretch_ocv_in(str_ocv),
    .hibernate_in(hib), .wake_out(wake), .sleep_out(sleep), .core_wr_in(core_wr),
    .core_addr_in(core_addr), .core_data_in(core_data), .wr_strobe_out(stb),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data), .last_used_profile_bit_in(lu_bit),
    .ocv_start_in(ev[0]), .ocv_meas_done_in(ev[1]), .ocv_load_high_in(ev[2] ^ ev[1]),
    .init_cmp_done_in(ev[2] & ~ev[1]), .ocv_done_flag_out(ocv_done),
    .ocv_invalid_flag_out(ocv_inv), .init_done_flag_out(init_done));
  gcp_host_model u_host (.mclk_in(mclk_in), .scl_in(scl_w), .sda_in(sda_w),
    .scl_low_out(h_scl), .sda_low_out(h_sda), .hang_out(hang));
  // wake pulses, stored bytes and longest stretch, away from the launching edge
  always @(negedge mclk_in) begin
    if (wake === 1'b1) wakes++;
    if (stb === 1'b1) strobes++;
    run = (scl_oe === 1'b1) ? run + 1 : 0;
    if (run > max_run) max_run = run;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // status byte expected from the profile pin
  function automatic logic [7:0] status_exp(input logic lu);
    return {7'h00, lu};
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // command write of two data bytes, acks returned
  task automatic wr2(input logic [7:0] cmd, d0, d1, output logic ac, a0, a1);
    logic aa;
    u_host.start();
    u_host.send({SLAVE_ADDR, 1'b0}, aa);
    u_host.send(cmd, ac);
    u_host.send(d0, a0);
    u_host.send(d1, a1);
    u_host.stop();
    check(8'(aa), 8'h1, "write address ack");
  endtask
  // two-byte read, first acked by master, second not
  task automatic rd2(input logic quick, input logic [7:0] cmd, output logic [7:0] d0, d1);
    logic a;
    u_host.start();
    if (!quick) begin
      u_host.send({SLAVE_ADDR, 1'b0}, a);
      u_host.send(cmd, a);
      u_host.start();
    end
    u_host.send({SLAVE_ADDR, 1'b1}, a);
    u_host.recv(1'b1, d0);
    u_host.recv(1'b0, d1);
    u_host.stop();
    check(8'(a), 8'h1, "read address ack");
  endtask
  task automatic pulse(input logic [2:0] m);
    @(negedge mclk_in) ev = m;
    @(negedge mclk_in) ev = 3'h0;
    repeat (2) @(negedge mclk_in);
  endtask
  // a hung run still ends through the closing report
  initial begin
    repeat (100000) @(posedge mclk_in);
    fail_count++;
    finish_test();
  end
  initial begin
    logic [7:0] loc, d0, d1, r0, r1;
    logic ac, a0, a1;
    int s0;
    void'($urandom(20));
    repeat (20) @(negedge mclk_in);
    reset_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    check(8'({ocv_done, ocv_inv, init_done, sleep, sda_oe, scl_oe}), 8'h0, "reset outputs");
    $display("test reset done");
    // random incremental writes, reads back and quick reads
    repeat (4) begin
      loc = 8'($urandom_range(0, 104));
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      s0 = strobes;
      wr2(loc, d0, d1, ac, a0, a1);
      check(8'({ac, a0, a1}), 8'h7, "write acks");
      check(8'(strobes - s0), 8'h2, "bytes stored");
      check(wr_addr, loc + 8'h1, "second byte location");
      // scaled host wait between a command and reading its result
      u_host.tick(HOST_WAIT);
      rd2(1'b0, loc, r0, r1);
      check(r0, d0, "read first");
      check(r1, d1, "read next");
      rd2(1'b1, 8'h00, r0, r1);
      check(r0, d1, "quick read at pointer");
    end
    $display("test write read done");
    // boundaries of the command space and the status byte
    s0 = strobes;
    wr2(8'h69, 8'h5a, 8'ha5, ac, a0, a1);
    check(8'({ac, a0, a1}), 8'h6, "write into status byte");
    check(8'(strobes - s0), 8'h1, "refused byte not stored");
    d1 = 8'($urandom);
    wr2(TOP_CMD, d1, 8'h00, ac, a0, a1);
    check(8'({ac, a0}), 8'h3, "top command accepted");
    wr2(TOP_CMD + 8'h1, 8'h00, 8'h00, ac, a0, a1);
    check(8'(ac), 8'h0, "command above top");
    for (int i = 0; i < 3; i++) begin
      lu_bit = i[0];
      rd2(1'b0, APP_STATUS_LOC, r0, r1);
      check(r0, status_exp(lu_bit), "profile status");
      check(r1, d1, "byte after status");
    end
    $display("test bounds done");
    // foreign address ignored, own address wakes once
    hib = 1'b1;
    s0 = wakes;
    u_host.start();
    u_host.send({SLAVE_ADDR ^ 7'($urandom_range(1, 127)), 1'b0}, ac);
    u_host.stop();
    check(8'({ac, 7'(wakes - s0)}), 8'h0, "foreign address");
    u_host.start();
    u_host.send({SLAVE_ADDR, 1'b0}, ac);
    u_host.stop();
    check(8'(wakes - s0), 8'h1, "own address wakes");
    hib = 1'b0;
    $display("test hibernate done");
    // core write reaches the command memory
    @(negedge mclk_in);
    core_addr = 8'($urandom_range(0, 105));
    core_data = 8'($urandom);
    core_wr = 1'b1;
    @(negedge mclk_in) core_wr = 1'b0;
    rd2(1'b0, core_addr, r0, r1);
    check(r0, core_data, "core written byte");
    // stretching capped by the selected limit
    for (int i = 0; i < 2; i++) begin
      str_ocv = i[0];
      str_req = 1'b1;
      max_run = 0;
      wr2(8'h20, 8'($urandom), 8'($urandom), ac, a0, a1);
      str_req = 1'b0;
      check(8'({ac, a0, a1}), 8'h7, "write under stretch");
      check(8'(max_run > (i ? FCAP : 0) && max_run <= (i ? OCAP : FCAP)), 8'h1, "stretch length");
    end
    $display("test stretch done");
    // measurement flags
    pulse(3'b100);
    check(8'(init_done), 8'h1, "init done");
    pulse(3'b001);
    pulse(3'b010);
    check(8'({ocv_done, ocv_inv}), 8'h3, "ocv done invalid");
    pulse(3'b001);
    check(8'({ocv_done, ocv_inv}), 8'h0, "ocv restart");
    pulse(3'b110);
    check(8'({ocv_done, ocv_inv}), 8'h2, "ocv done valid");
    pulse(3'b011);
    check(8'({ocv_done, ocv_inv}), 8'h3, "done beats restart");
    $display("test flags done");
    // stuck data line: release then sleep
    tmo = 8'h01;
    u_host.hold(1'b1);
    u_host.tick(UNIT - 20);
    check(8'(sleep), 8'h0, "no sleep before timeout");
    u_host.tick(40);
    check(8'({sleep, sda_oe, scl_oe}), 8'h4, "stuck bus");
    u_host.hold(1'b0);
    u_host.tick(10);
    check(8'(sleep), 8'h0, "bus free again");
    // device ack held by a frozen clock is released by the timeout
    d0 = {SLAVE_ADDR, 1'b0};
    u_host.start();
    for (int i = 7; i >= 0; i--) begin
      u_host.bit_x(d0[i], a0);
    end
    u_host.tick(UNIT - 20);
    check(8'(sda_oe), 8'h1, "ack held before timeout");
    u_host.tick(40);
    check(8'({sleep, sda_oe}), 8'h2, "ack freed, clock stuck");
    u_host.stop();
    tmo = 8'h00;
    $display("test timeout done");
    check(8'(hang), 8'h0, "clock never hung");
    finish_test();
  end
endmodule
`default_nettype wire
